// *** pkg/txas_map.vh ***
// register map, field layout, reset values and scaling constants of the tx amplitude block
`ifndef TXAS_MAP_VH
`define TXAS_MAP_VH

// register indices inside one channel window; byte address is four times the index
`define TXAS_IDX_SCALE 6'h07
`define TXAS_IDX_CTRL 6'h08
`define TXAS_IDX_SAMPLE 6'h09
`define TXAS_CH0_SLOT 5'h1F
`define TXAS_NUM_CH 16

// reset values
`define TXAS_SCALE_RST 6'h36
`define TXAS_CTRL_RST 7'h00
`define TXAS_SAMPLE_RST 7'h00

// field positions
`define TXAS_CTRL_EN_BIT 6
`define TXAS_CTRL_DIR_BIT 5
`define TXAS_TSEL_USER_BIT 3

// sample ram
`define TXAS_LAST_LOC 5'h13
`define TXAS_RAM_AW 9
`define TXAS_RAM_DEPTH 512

// amplitude scaling, in percent of nominal
`define TXAS_PCT_NOM 10'h064
`define TXAS_T1_NOM 6'h36
`define TXAS_T1_STEP 10'h002
`define TXAS_T1_MAX 10'h078
`define TXAS_E1_NOM 6'h21
`define TXAS_E1_STEP 10'h003
`define TXAS_E1_MAX 10'h0C8

`endif

// *** design/txas_sample_ram.v ***
// arbitrary-waveform sample memory with registered read data
`timescale 1ns/10ps
`include "txas_map.vh"

module txas_sample_ram (
  // clock
  input wire core_clk,
  // access
  input wire wr_en,
  input wire rd_en,
  input wire [`TXAS_RAM_AW-1:0] addr,
  input wire [6:0] wdata,
  output reg [6:0] rdata
);

  reg [6:0] mem [0:`TXAS_RAM_DEPTH-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule

// *** design/txas_regs.v ***
// per-channel amplitude scaling and waveform sample ram access registers on avalon-mm
`timescale 1ns/10ps
`include "txas_map.vh"

module txas_regs (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // avalon-mm slave
  input wire [12:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // per-channel mode and template select from neighbouring logic on core_clk
  input wire [15:0] e1_mode,
  input wire [63:0] waveform_template_select,
  // per-channel transmit amplitude in percent of nominal
  output wire [127:0] tx_amplitude_pct
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RAM_WR = 2'b01;
  localparam ST_RAM_RD = 2'b10;
  localparam ST_RAM_CAP = 2'b11;

  reg [5:0] amplitude_scale_code_r [0:`TXAS_NUM_CH-1];
  reg [6:0] ctrl_r [0:`TXAS_NUM_CH-1];
  reg [6:0] template_sample_value_r [0:`TXAS_NUM_CH-1];
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [3:0] op_ch_r;
  reg [31:0] rd_val;
  integer i;

  // address decode: channels 1..15 at 0x40 stride, channel 0 in the top slot
  wire [10:0] idx = avs_address[12:2];
  wire [4:0] slot = idx[10:6];
  wire [5:0] low = idx[5:0];
  wire slot_ok = ((slot != 5'h00) && !slot[4]) || (slot == `TXAS_CH0_SLOT);
  wire [3:0] ch = (slot == `TXAS_CH0_SLOT) ? 4'h0 : slot[3:0];
  wire hit_scale = slot_ok && (low == `TXAS_IDX_SCALE);
  wire hit_ctrl = slot_ok && (low == `TXAS_IDX_CTRL);
  wire hit_sample = slot_ok && (low == `TXAS_IDX_SAMPLE);

  // one request taken per idle cycle; waitrequest drops for exactly one cycle
  wire req = avs_read | avs_write;
  wire accept = req && avs_waitrequest && (st_r == ST_IDLE);
  wire wr_acc = accept && avs_write && avs_byteenable[0];

  // template select of the addressed channel and of the channel under operation
  wire [3:0] tsel_ch = waveform_template_select[ch*4 +: 4];
  wire user_ch = tsel_ch[`TXAS_TSEL_USER_BIT];
  wire [3:0] tsel_op = waveform_template_select[op_ch_r*4 +: 4];
  wire user_op = tsel_op[`TXAS_TSEL_USER_BIT];

  // control fields as written by this request, and as now held in ctrl_r for the addressed channel
  wire new_en = avs_writedata[`TXAS_CTRL_EN_BIT];
  wire new_rd = avs_writedata[`TXAS_CTRL_DIR_BIT];
  wire cur_en = ctrl_r[ch][`TXAS_CTRL_EN_BIT];
  wire cur_rd = ctrl_r[ch][`TXAS_CTRL_DIR_BIT];

  // sample index saturates at the last location
  wire [4:0] op_idx = ctrl_r[op_ch_r][4:0];
  wire [4:0] op_loc = (op_idx > `TXAS_LAST_LOC) ? `TXAS_LAST_LOC : op_idx;
  wire [`TXAS_RAM_AW-1:0] ram_addr = {op_ch_r, op_loc};
  wire ram_we = (st_r == ST_RAM_WR) && user_op;
  wire ram_re = (st_r == ST_RAM_RD) && user_op;
  wire [6:0] ram_rdata;

  txas_sample_ram u_ram (
    .core_clk(core_clk),
    .wr_en(ram_we),
    .rd_en(ram_re),
    .addr(ram_addr),
    .wdata(template_sample_value_r[op_ch_r]),
    .rdata(ram_rdata)
  );

  // read data; reserved and unmapped bits read zero
  always @* begin
    rd_val = 32'h00000000;
    if (hit_scale) begin
      rd_val = {26'h0000000, amplitude_scale_code_r[ch]};
    end else if (hit_ctrl) begin
      rd_val = {25'h0000000, ctrl_r[ch]};
    end else if (hit_sample) begin
      rd_val = {25'h0000000, template_sample_value_r[ch]};
    end
  end

  // ram access sequencer, started by a register write
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (wr_acc && hit_ctrl && new_en && user_ch) begin
          st_nxt = new_rd ? ST_RAM_RD : ST_RAM_WR;
        end else if (wr_acc && hit_sample && cur_en && !cur_rd && user_ch) begin
          st_nxt = ST_RAM_WR;
        end
      end
      ST_RAM_WR: begin
        st_nxt = ST_IDLE;
      end
      ST_RAM_RD: begin
        st_nxt = ST_RAM_CAP;
      end
      ST_RAM_CAP: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      op_ch_r <= 4'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      for (i = 0; i < `TXAS_NUM_CH; i = i + 1) begin
        amplitude_scale_code_r[i] <= `TXAS_SCALE_RST;
        ctrl_r[i] <= `TXAS_CTRL_RST;
        template_sample_value_r[i] <= `TXAS_SAMPLE_RST;
      end
    end else begin
      st_r <= st_nxt;
      avs_waitrequest <= !accept;
      if (accept) begin
        avs_readdata <= avs_read ? rd_val : 32'h00000000;
        op_ch_r <= ch;
      end
      if (wr_acc && hit_scale) begin
        amplitude_scale_code_r[ch] <= avs_writedata[5:0];
      end
      if (wr_acc && hit_ctrl) begin
        ctrl_r[ch] <= avs_writedata[6:0];
      end
      if (wr_acc && hit_sample) begin
        template_sample_value_r[ch] <= avs_writedata[6:0];
      end
      if ((st_r == ST_RAM_CAP) && user_op) begin
        template_sample_value_r[op_ch_r] <= ram_rdata;
      end
    end
  end

  // amplitude in percent: nominal plus step times code offset, clamped to the mode range
  genvar g;
  generate
    for (g = 0; g < `TXAS_NUM_CH; g = g + 1) begin : g_amp
      reg [7:0] amp_r;
      wire e1 = e1_mode[g];
      wire [9:0] step = e1 ? `TXAS_E1_STEP : `TXAS_T1_STEP;
      wire [9:0] nom = e1 ? {4'h0, `TXAS_E1_NOM} : {4'h0, `TXAS_T1_NOM};
      wire [9:0] lim = e1 ? `TXAS_E1_MAX : `TXAS_T1_MAX;
      wire [9:0] up = `TXAS_PCT_NOM + step * {4'h0, amplitude_scale_code_r[g]};
      wire [9:0] dn = step * nom;
      wire [9:0] dev = (up > dn) ? up - dn : 10'h000;
      always @(posedge core_clk) begin
        if (!rst_b) begin
          amp_r <= 8'h64;
        end else begin
          amp_r <= (dev > lim) ? lim[7:0] : dev[7:0];
        end
      end
      assign tx_amplitude_pct[g*8 +: 8] = amp_r;
    end
  endgenerate

endmodule

// *** testbench/txas_regs_monitor.sv ***
// checker for the tx amplitude register block
`timescale 1ns/10ps
module txas_regs_monitor (
  // watched ports
  input wire core_clk,
  input wire rst_b,
  input wire [12:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [15:0] e1_mode,
  input wire [127:0] tx_amplitude_pct
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire [4:0] sl = avs_address[12:8];
  wire [5:0] ix = avs_address[7:2];
  wire [7:0] p = tx_amplitude_pct[7:0];
  wire an = !avs_waitrequest;
  wire rq = avs_read || avs_write;
  wire um = ix < 7 || ix > 9 || sl == 0 || (sl > 15 && sl != 31);
  AST_WAIT: assert property (an |=> !an) else $error("wait");
  AST_ANS: assert property ($rose(rq) |-> ##[1:6] an) else $error("ans");
  AST_SPUR: assert property (an |-> $past(rq)) else $error("spur");
  AST_UNM: assert property (an && avs_read && um |-> avs_readdata == 0) else $error("unm");
  AST_RSV: assert property (an && avs_read |-> avs_readdata[31:7] == 0) else $error("rsv");
  AST_RSV_SC: assert property (an && avs_read && ix == 7 |-> !avs_readdata[6]) else $error("sc");
  AST_T1: assert property (!e1_mode[0] [*2] |-> !p[0] && p <= 120) else $error("t1");
  AST_E1: assert property (e1_mode[0] [*2] |-> p % 3 == 1 || p == 0) else $error("e1");
endmodule
bind txas_regs txas_regs_monitor u_mon (.core_clk, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .e1_mode, .tx_amplitude_pct);

// *** testbench/txas_regs_tb.sv ***
// bench for the tx amplitude register block
`timescale 1ns/10ps
module txas_regs_tb;
  reg core_clk = 0, rst_b = 0, rd = 0, wr = 0;
  reg [12:0] adr = 0;
  reg [7:0] wd = 0;
  reg [7:0] rv = 0;
  reg [3:0] be = 4'hF;
  reg [15:0] e1 = 0;
  reg [63:0] ts = 0;
  reg [28:0] rows [0:2];
  wire [31:0] rdat;
  wire [127:0] pct;
  wire wt;
  integer errors = 0, checks_done = 0, i, n, v;
  txas_regs uut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata({24'h0, wd}), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .e1_mode(e1), .waveform_template_select(ts), .tx_amplitude_pct(pct));
  initial forever #5 core_clk = ~core_clk;
  task chk(input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] reg %h exp %h got %h", adr, e, g);
    end
  endtask
  task chk_amp(input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] amplitude exp %0d got %0d", e, g);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge; read data taken there
  task bus(input [12:0] a, input w, input [7:0] d);
    @(posedge core_clk);
    adr <= a;
    wd <= d;
    {rd, wr} <= {!w, w};
    n = 0;
    @(posedge core_clk);
    while (wt !== 1'b0 && n < 50) begin
      n = n + 1;
      @(posedge core_clk);
    end
    if (n == 50) errors = errors + 1;
    rv = rdat[7:0];
    {rd, wr} <= 2'h0;
  endtask
  task rc(input [12:0] a, input [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(e, rv);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000 errors = errors + 1;
    stop_test;
  end
  initial begin
    rows[0] = {13'h1F1C, 8'hFF, 8'h3F};
    rows[1] = {13'h0F20, 8'hFF, 8'h7F};
    rows[2] = {13'h0724, 8'hFF, 8'h7F};
    repeat (6) @(posedge core_clk);
    rst_b <= 1;
    rc(13'h1F1C, 8'h36);
    chk_amp(8'h64, pct[7:0]);
    rc(13'h0920, 8'h00);
    rc(13'h0924, 8'h00);
    rc(13'h001C, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      bus(rows[i][28:16], 1'b1, rows[i][15:8]);
      rc(rows[i][28:16], rows[i][7:0]);
    end
    // a write with byte lane 0 off must leave the register alone
    be <= 4'h0;
    bus(13'h1F1C, 1'b1, 8'h21);
    be <= 4'hF;
    rc(13'h1F1C, 8'h3F);
    for (i = 0; i < 128; i = i + 1) begin
      e1[0] <= i[6];
      bus(13'h1F1C, 1'b1, {2'h0, i[5:0]});
      v = i[6] ? 3 * i[5:0] + 1 : 2 * i[5:0] - 8;
      if (v < 0) v = 0;
      repeat (2) @(posedge core_clk);
      chk_amp(v[7:0], pct[7:0]);
    end
    // other channels keep their own mode and code
    e1[15] <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk_amp(8'hA3, pct[127:120]);
    chk_amp(8'h64, pct[15:8]);
    ts[11:8] <= 4'h8;
    for (i = 0; i < 4; i = i + 1) begin
      v = (i == 3) ? 25 : (i == 2) ? 19 : 18 * i;
      bus(13'h0220, 1'b1, {3'h0, v[4:0]});
      bus(13'h0224, 1'b1, {3'h1, v[4:0]});
      bus(13'h0220, 1'b1, {3'h2, v[4:0]});
    end
    ts[11:8] <= 4'h0;
    bus(13'h0224, 1'b1, 8'h55);
    bus(13'h0220, 1'b1, 8'h40);
    ts[11:8] <= 4'h8;
    for (i = 0; i < 4; i = i + 1) begin
      v = (i == 3) ? 31 : (i == 2) ? 19 : 18 * i;
      bus(13'h0220, 1'b1, {3'h3, v[4:0]});
      rc(13'h0224, (i == 0) ? 8'h20 : (i == 1) ? 8'h32 : 8'h39);
    end
    // sample write while enabled in write direction goes to the ram
    bus(13'h0220, 1'b1, 8'h45);
    bus(13'h0224, 1'b1, 8'h4A);
    bus(13'h0220, 1'b1, 8'h05);
    bus(13'h0224, 1'b1, 8'h11);
    rc(13'h0224, 8'h11);
    bus(13'h0220, 1'b1, 8'h65);
    rc(13'h0224, 8'h4A);
    // reset in mid-run brings every register back to its default
    rst_b <= 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    rc(13'h0220, 8'h00);
    rc(13'h0224, 8'h00);
    rc(13'h1F1C, 8'h36);
    chk_amp(8'hA3, pct[7:0]);
    stop_test;
  end
endmodule
